// file: dcff_pkg.sv
// Shared constants for the single clock flagged buffer
package dcff_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 18;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned CNT_W = 12;
  // Words held in the array (standard depth)
  localparam logic [CNT_W-1:0] STD_DEPTH = 12'h0800;
  // Fall-through adds the output register as one more word
  localparam logic [CNT_W-1:0] FALL_THROUGH_MODE_DEPTH = 12'h0801;

  // ----------------------------------------------------------------
  // Flag offsets
  // ----------------------------------------------------------------
  // Width of each serially loaded offset in the 18-bit port modes
  localparam int unsigned OFF_W = 11;
  localparam logic [OFF_W-1:0] PAE_OFF_RST = 11'h007F;
  localparam logic [OFF_W-1:0] PAF_OFF_RST = 11'h007F;

  // ----------------------------------------------------------------
  // Mark spacing expected from the controller, in words
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] MARK_MIN_WORDS = 12'h0010;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PTR_RST = 11'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;

endpackage : dcff_pkg

// file: dcff_mem.sv
// Flip-flop storage array of the buffer
module dcff_mem
(
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [dcff_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [dcff_pkg::DATA_W-1:0] i_wr_data,
  // Read port, combinational
  input wire logic [dcff_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [dcff_pkg::DATA_W-1:0] o_rd_data
);

  typedef struct packed
  {
    logic [(1 << dcff_pkg::ADDR_W)-1:0][dcff_pkg::DATA_W-1:0] mem;
  } dcff_mem_s;

  dcff_mem_s mem_ff;
  dcff_mem_s nxt_mem;

  // ----------------------------------------------------------------
  // Storage update
  // ----------------------------------------------------------------
  // Data words need no reset; every word is written before it is read
  always_comb
  begin
    nxt_mem = mem_ff;
    if (i_wr_en)
    begin
      nxt_mem.mem[i_wr_addr] = i_wr_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    mem_ff <= nxt_mem;
  end

  assign o_rd_data = mem_ff.mem[i_rd_addr];

endmodule : dcff_mem

// file: dcff_fifo.sv
// Flagged buffer with standard and fall-through read modes, mark and retransmit
module dcff_fifo
(
  // Clock and resets
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PART_RST,
  // Mode straps, taken during master reset
  input wire logic I_FALL_THROUGH_MODE,
  input wire logic I_FLAG_TIMING_SEL,
  // Write side
  input wire logic I_WR_EN_N,
  input wire logic I_WR_CHIP_SEL_N,
  input wire logic [dcff_pkg::DATA_W-1:0] I_WR_DATA,
  // Read side
  input wire logic I_RD_EN_N,
  input wire logic I_RD_CHIP_SEL_N,
  input wire logic I_OUT_EN_N,
  // Mark and retransmit
  input wire logic I_MARK_N,
  input wire logic I_RETRANSMIT_N,
  // Serial offset loading
  input wire logic I_OFFSET_LOAD_N,
  input wire logic I_SER_EN_N,
  input wire logic I_SER_IN,
  // Data out
  output logic [dcff_pkg::DATA_W-1:0] O_RD_DATA_OUT,
  output logic O_RD_DATA_OE,
  // Status flags
  output logic O_FULL_N,
  output logic O_EMPTY_N,
  output logic O_IN_READY_N,
  output logic O_OUT_READY_N,
  output logic O_ALMOST_FULL_N,
  output logic O_ALMOST_EMPTY_N,
  output logic O_SYNC_FLAG_MODE
);

  typedef struct packed
  {
    logic [dcff_pkg::ADDR_W-1:0] wr_ptr;
    logic [dcff_pkg::ADDR_W-1:0] rd_ptr;
    logic [dcff_pkg::ADDR_W-1:0] mark_ptr;
    logic [dcff_pkg::CNT_W-1:0] cnt;
    logic [dcff_pkg::CNT_W-1:0] mark_cnt;
    logic mark_vld;
    logic fall_through_mode;
    logic sync_flags;
    logic [dcff_pkg::OFF_W-1:0] pae_off;
    logic [dcff_pkg::OFF_W-1:0] paf_off;
    logic [dcff_pkg::DATA_W-1:0] dout;
    logic dout_vld;
    logic rt_busy;
    logic oe;
    logic empty_n;
    logic out_ready_n;
    logic full_n;
    logic in_ready_n;
    logic almost_full_n;
    logic almost_empty_n;
  } dcff_state_s;

  dcff_state_s st_ff;
  dcff_state_s nxt_st;
  logic [dcff_pkg::DATA_W-1:0] mem_rd_data;
  logic wr_go;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pointer wrap is free since the array depth is a power of two
  function automatic logic [dcff_pkg::ADDR_W-1:0] ptr_inc(input logic [dcff_pkg::ADDR_W-1:0] p);
    ptr_inc = p + 11'h001;
  endfunction : ptr_inc

  // Count after one optional push and one optional pop
  function automatic logic [dcff_pkg::CNT_W-1:0] cnt_upd(input logic [dcff_pkg::CNT_W-1:0] c,
                                                          input logic push, input logic pop);
    cnt_upd = c + {11'h000, push} - {11'h000, pop};
  endfunction : cnt_upd

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dcff_mem u_mem
  (
    .i_clk(I_CLK),
    .i_wr_en(wr_go),
    .i_wr_addr(st_ff.wr_ptr),
    .i_wr_data(I_WR_DATA),
    .i_rd_addr(st_ff.rd_ptr),
    .o_rd_data(mem_rd_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic rst_any;
    logic room;
    logic rd_req;
    logic rd_go;
    logic do_rt;
    logic set_mark;
    logic [dcff_pkg::CNT_W-1:0] used;
    logic [dcff_pkg::CNT_W-1:0] cap;
    rst_any = I_SYS_RST || I_PART_RST;
    rd_go = 1'b0;
    used = dcff_pkg::CNT_RST;
    cap = dcff_pkg::STD_DEPTH;
    nxt_st = st_ff;
    // Marked data counts against space while a mark stands
    room = (st_ff.mark_vld ? st_ff.mark_cnt : st_ff.cnt) != dcff_pkg::STD_DEPTH;
    rd_req = !I_RD_EN_N && !I_RD_CHIP_SEL_N;
    do_rt = !I_RETRANSMIT_N && st_ff.mark_vld;
    set_mark = !I_MARK_N && !st_ff.mark_vld;
    wr_go = !I_WR_EN_N && !I_WR_CHIP_SEL_N && room && !rst_any;
    if (st_ff.fall_through_mode)
    begin
      rd_go = (st_ff.cnt != dcff_pkg::CNT_RST) && (!st_ff.dout_vld || rd_req) && !do_rt;
    end
    else
    begin
      rd_go = rd_req && (st_ff.cnt != dcff_pkg::CNT_RST) && !st_ff.rt_busy && !do_rt;
    end

    // Data path and pointers
    if (rd_go)
    begin
      nxt_st.dout = mem_rd_data;
      nxt_st.dout_vld = 1'b1;
      nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
    end
    else if (st_ff.fall_through_mode && rd_req && st_ff.dout_vld)
    begin
      nxt_st.dout_vld = 1'b0; // Last word taken, nothing behind it
    end
    if (wr_go)
    begin
      nxt_st.wr_ptr = ptr_inc(st_ff.wr_ptr);
    end
    nxt_st.cnt = cnt_upd(st_ff.cnt, wr_go, rd_go);
    nxt_st.mark_cnt = cnt_upd(st_ff.mark_cnt, wr_go, 1'b0);
    nxt_st.rt_busy = do_rt;

    // Mark follows its request level; set captures the read position
    if (set_mark)
    begin
      nxt_st.mark_vld = 1'b1;
      nxt_st.mark_ptr = st_ff.rd_ptr;
      nxt_st.mark_cnt = cnt_upd(st_ff.cnt, wr_go, 1'b0);
    end
    else if (I_MARK_N)
    begin
      nxt_st.mark_vld = 1'b0;
    end
    if (do_rt)
    begin
      nxt_st.rd_ptr = st_ff.mark_ptr;
      nxt_st.cnt = cnt_upd(st_ff.mark_cnt, wr_go, 1'b0);
      nxt_st.dout_vld = 1'b0;
    end

    if (!I_OFFSET_LOAD_N && !I_SER_EN_N)
    begin
      {nxt_st.paf_off, nxt_st.pae_off} = {st_ff.paf_off[dcff_pkg::OFF_W-2:0], st_ff.pae_off, I_SER_IN};
    end

    nxt_st.oe = !I_OUT_EN_N && (rst_any || !I_RD_CHIP_SEL_N);

    // Flags come from the settled count, which gives the one-cycle lag
    // empty release
    nxt_st.empty_n = st_ff.fall_through_mode || ((st_ff.cnt != dcff_pkg::CNT_RST) && !st_ff.rt_busy);
    nxt_st.out_ready_n = !st_ff.fall_through_mode || !st_ff.dout_vld;
    nxt_st.full_n = st_ff.fall_through_mode || room;
    nxt_st.in_ready_n = !st_ff.fall_through_mode || !room;
    cap = st_ff.fall_through_mode ? dcff_pkg::FALL_THROUGH_MODE_DEPTH : dcff_pkg::STD_DEPTH;
    used = cnt_upd(st_ff.cnt, st_ff.fall_through_mode && st_ff.dout_vld, 1'b0);
    nxt_st.almost_full_n = used < (cap - {1'b0, st_ff.paf_off});
    nxt_st.almost_empty_n = used > {1'b0, st_ff.pae_off};

    // Partial reset clears data but keeps offsets and modes
    if (rst_any)
    begin
      nxt_st.wr_ptr = dcff_pkg::PTR_RST;
      nxt_st.rd_ptr = dcff_pkg::PTR_RST;
      nxt_st.mark_ptr = dcff_pkg::PTR_RST;
      nxt_st.cnt = dcff_pkg::CNT_RST;
      nxt_st.mark_cnt = dcff_pkg::CNT_RST;
      nxt_st.mark_vld = 1'b0;
      nxt_st.dout = dcff_pkg::DATA_RST;
      nxt_st.dout_vld = 1'b0;
      nxt_st.rt_busy = 1'b0;
      nxt_st.empty_n = 1'b0;
      nxt_st.out_ready_n = 1'b1;
      nxt_st.full_n = 1'b1;
      nxt_st.in_ready_n = 1'b1;
      nxt_st.almost_full_n = 1'b1;
      nxt_st.almost_empty_n = 1'b0;
    end
    // Master reset also restores offsets and samples the straps
    if (I_SYS_RST)
    begin
      nxt_st.fall_through_mode = I_FALL_THROUGH_MODE;
      nxt_st.sync_flags = I_FLAG_TIMING_SEL;
      nxt_st.pae_off = dcff_pkg::PAE_OFF_RST;
      nxt_st.paf_off = dcff_pkg::PAF_OFF_RST;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset is applied in the next-state logic so straps can be sampled
  always_ff @(posedge I_CLK)
  begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign O_RD_DATA_OUT = st_ff.dout;
  assign O_RD_DATA_OE = st_ff.oe;
  assign O_FULL_N = st_ff.full_n;
  assign O_EMPTY_N = st_ff.empty_n;
  assign O_IN_READY_N = st_ff.in_ready_n;
  assign O_OUT_READY_N = st_ff.out_ready_n;
  assign O_ALMOST_FULL_N = st_ff.almost_full_n;
  assign O_ALMOST_EMPTY_N = st_ff.almost_empty_n;
  assign O_SYNC_FLAG_MODE = st_ff.sync_flags;

endmodule : dcff_fifo

// file: dcff_assertions.sv
// Port-level checker for the flagged buffer
module dcff_assertions
(
  // Clock and resets
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PART_RST,
  input wire logic I_FALL_THROUGH_MODE,
  // Requests
  input wire logic I_WR_EN_N,
  input wire logic I_WR_CHIP_SEL_N,
  input wire logic I_RD_EN_N,
  input wire logic I_RD_CHIP_SEL_N,
  input wire logic I_OUT_EN_N,
  input wire logic I_MARK_N,
  input wire logic I_RETRANSMIT_N,
  // Observed outputs
  input wire logic [dcff_pkg::DATA_W-1:0] O_RD_DATA_OUT,
  input wire logic O_RD_DATA_OE,
  input wire logic O_FULL_N,
  input wire logic O_EMPTY_N,
  input wire logic O_OUT_READY_N,
  input wire logic O_ALMOST_FULL_N,
  input wire logic O_ALMOST_EMPTY_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ftm_ff;
  logic seen_ff = 1'b0;
  logic wr;
  logic rd;
  // Request decode
  assign wr = !I_WR_EN_N && !I_WR_CHIP_SEL_N;
  assign rd = !I_RD_EN_N && !I_RD_CHIP_SEL_N;
  // Mode is only known from the strap seen in master reset
  always_ff @(posedge I_CLK)
  begin
    seen_ff <= 1'b1;
    if (I_SYS_RST)
      ftm_ff <= I_FALL_THROUGH_MODE;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST || I_PART_RST);
  sequence s_no_rd;
    I_RD_EN_N && I_RETRANSMIT_N;
  endsequence
  sequence s_no_wr;
    I_WR_EN_N && I_RETRANSMIT_N && I_MARK_N;
  endsequence
  a_empty_release: assert property ((!ftm_ff && !O_EMPTY_N && wr) ##0 s_no_rd ##1 s_no_rd |=> O_EMPTY_N)
    else $error("empty flag late");
  a_ready_rise: assert property ((ftm_ff && O_OUT_READY_N && wr) ##0 s_no_rd ##1 s_no_rd[*2] |=> !O_OUT_READY_N)
    else $error("output ready late");
  a_full_release: assert property ((!ftm_ff && !O_FULL_N && rd) ##0 s_no_wr ##1 s_no_wr |=> O_FULL_N)
    else $error("full flag late");
  a_af_cause: assert property ($rose(O_ALMOST_FULL_N) |-> $past(rd, 2))
    else $error("almost full left without a read");
  a_ae_cause: assert property ($rose(O_ALMOST_EMPTY_N) |-> $past(wr, 2)
    || !$past(I_RETRANSMIT_N, 2) || !$past(I_RETRANSMIT_N, 3))
    else $error("almost empty left without a write");
  a_rd_ignored: assert property ((!ftm_ff && !O_EMPTY_N && I_RETRANSMIT_N && $past(I_WR_EN_N)
    && $past(I_RETRANSMIT_N) && $past(I_RETRANSMIT_N, 2)) |=> $stable(O_RD_DATA_OUT))
    else $error("read taken while empty");
  // Ready lags one cycle, so a read or retransmit just before may still drop the word
  a_ft_hold: assert property ((ftm_ff && !O_OUT_READY_N && I_RETRANSMIT_N
    && (I_RD_EN_N || I_RD_CHIP_SEL_N) && !$past(rd) && $past(I_RETRANSMIT_N))
    |=> !O_OUT_READY_N && $stable(O_RD_DATA_OUT))
    else $error("word left without both enables");
  a_oe_gate: assert property (disable iff (!seen_ff) O_RD_DATA_OE == (!$past(I_OUT_EN_N)
    && ($past(I_SYS_RST || I_PART_RST) || !$past(I_RD_CHIP_SEL_N))))
    else $error("output drive gating wrong");
endmodule : dcff_assertions

bind dcff_fifo dcff_assertions i_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_PART_RST(I_PART_RST),
  .I_FALL_THROUGH_MODE(I_FALL_THROUGH_MODE), .I_WR_EN_N(I_WR_EN_N), .I_WR_CHIP_SEL_N(I_WR_CHIP_SEL_N),
  .I_RD_EN_N(I_RD_EN_N), .I_RD_CHIP_SEL_N(I_RD_CHIP_SEL_N), .I_OUT_EN_N(I_OUT_EN_N), .I_MARK_N(I_MARK_N),
  .I_RETRANSMIT_N(I_RETRANSMIT_N), .O_RD_DATA_OUT(O_RD_DATA_OUT), .O_RD_DATA_OE(O_RD_DATA_OE),
  .O_FULL_N(O_FULL_N), .O_EMPTY_N(O_EMPTY_N), .O_OUT_READY_N(O_OUT_READY_N),
  .O_ALMOST_FULL_N(O_ALMOST_FULL_N), .O_ALMOST_EMPTY_N(O_ALMOST_EMPTY_N));

// file: dcff_writer.sv
// Writer-side model feeding counting words into the buffer
module dcff_writer
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // One word per cycle while high
  input wire logic i_go,
  // Write side of the buffer
  output logic o_wr_en_n,
  output logic o_wr_cs_n,
  output logic [dcff_pkg::DATA_W-1:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [dcff_pkg::DATA_W-1:0] cnt_ff;
  // Idle bus shows the inverse so a stale word never looks valid
  always_ff @(posedge i_clk)
  begin
    o_wr_en_n <= !i_go;
    o_wr_cs_n <= !i_go;
    o_wr_data <= i_rst ? '0 : (i_go ? cnt_ff : ~o_wr_data);
    cnt_ff <= i_rst ? '0 : cnt_ff + {17'h0_0000, i_go};
  end
endmodule : dcff_writer

// file: tb.sv
// Self-checking bench for the flagged buffer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic prst = 1'b0;
  logic ftm = 1'b0;
  logic go = 1'b0;
  logic ren_n = 1'b1;
  logic rd_chip_sel_n = 1'b0;
  logic oe_n = 1'b0;
  logic mark_n = 1'b1;
  logic retransmit_n = 1'b1;
  logic offset_load_n = 1'b1;
  logic ser_n = 1'b1;
  logic ser_in = 1'b0;
  logic wen_n, wcs_n, oe, full_n, empty_n, in_ready_n, out_ready_n, almost_full_n, almost_empty_n, sfm;
  logic [17:0] wdata, q;
  int fails = 0;
  int n_checks = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  dcff_writer i_wr (.i_clk(clk), .i_rst(rst || prst), .i_go(go), .o_wr_en_n(wen_n), .o_wr_cs_n(wcs_n),
    .o_wr_data(wdata));
  dcff_fifo i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_PART_RST(prst), .I_FALL_THROUGH_MODE(ftm),
    .I_FLAG_TIMING_SEL(ftm), .I_WR_EN_N(wen_n), .I_WR_CHIP_SEL_N(wcs_n), .I_WR_DATA(wdata),
    .I_RD_EN_N(ren_n), .I_RD_CHIP_SEL_N(rd_chip_sel_n), .I_OUT_EN_N(oe_n), .I_MARK_N(mark_n),
    .I_RETRANSMIT_N(retransmit_n), .I_OFFSET_LOAD_N(offset_load_n), .I_SER_EN_N(ser_n), .I_SER_IN(ser_in),
    .O_RD_DATA_OUT(q), .O_RD_DATA_OE(oe), .O_FULL_N(full_n), .O_EMPTY_N(empty_n), .O_IN_READY_N(in_ready_n),
    .O_OUT_READY_N(out_ready_n), .O_ALMOST_FULL_N(almost_full_n), .O_ALMOST_EMPTY_N(almost_empty_n),
    .O_SYNC_FLAG_MODE(sfm));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Partner writes n words, one per cycle
  task automatic wr(input int n);
    @(posedge clk) go <= 1'b1;
    repeat (n) @(posedge clk);
    go <= 1'b0;
  endtask : wr
  // idle between reads
  // Enable returns high after each read, so reads never come back to back
  task automatic rd1(input logic [17:0] exp);
    @(posedge clk) ren_n <= 1'b0;
    @(posedge clk) ren_n <= 1'b1;
    #1 chk(q, exp);
  endtask : rd1
  // Master reset; read select starts high in fall-through
  task automatic do_rst(input logic ft);
    @(posedge clk) rst <= 1'b1;
    ftm <= ft;
    mark_n <= 1'b1;
    rd_chip_sel_n <= ft;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk(sfm, ft);
  endtask : do_rst
  task automatic t_std();
    localparam logic [21:0] OFFS = 22'h00_1803;
    int i;
    do_rst(1'b0);
    chk(empty_n, 1'b0);
    for (i = 21; i >= 0; i--)
    begin
      @(posedge clk) offset_load_n <= 1'b0;
      ser_n <= 1'b0;
      ser_in <= OFFS[i];
    end
    @(posedge clk) offset_load_n <= 1'b1;
    ser_n <= 1'b1;
    wr(3);
    cyc(3);
    chk(almost_empty_n, 1'b0);
    wr(1);
    cyc(3);
    chk(almost_empty_n, 1'b1);
    for (i = 0; i < 4; i++)
      rd1(i);
    rd1(18'h0_0003);
    wr(2048);
    wr(1);
    cyc(3);
    chk({full_n, almost_full_n}, 2'b00);
    rd1(18'h0_0004);
    cyc(1);
    chk(full_n, 1'b1);
    rd1(18'h0_0005);
    rd1(18'h0_0006);
    cyc(1);
    chk(almost_full_n, 1'b0);
    rd1(18'h0_0007);
    cyc(1);
    chk(almost_full_n, 1'b1);
    $display("standard test done");
  endtask : t_std
  task automatic t_ft();
    do_rst(1'b1);
    chk(in_ready_n, 1'b0);
    wr(2);
    cyc(3);
    chk(out_ready_n, 1'b0);
    chk(q, 18'h0_0000);
    // select before enable
    // Select two cycles ahead of enable so the head word stays
    @(posedge clk) rd_chip_sel_n <= 1'b0;
    cyc(1);
    chk(q, 18'h0_0000);
    rd1(18'h0_0001);
    wr(2047);
    cyc(3);
    chk(in_ready_n, 1'b0);
    wr(1);
    cyc(3);
    chk(in_ready_n, 1'b1);
    rd1(18'h0_0002);
    cyc(1);
    chk(in_ready_n, 1'b0);
    $display("fall-through test done");
  endtask : t_ft
  task automatic t_mark();
    int i;
    logic seen;
    do_rst(1'b0);
    @(posedge clk) prst <= 1'b1;
    rd_chip_sel_n <= 1'b1;
    cyc(3);
    chk(oe, 1'b1);
    @(posedge clk) prst <= 1'b0;
    rd_chip_sel_n <= 1'b0;
    // More than the minimum spacing before the mark
    wr(20);
    @(posedge clk) mark_n <= 1'b0;
    cyc(2);
    for (i = 0; i < 5; i++)
      rd1(i);
    // One word beyond the marked space would wrap onto word zero
    wr(2029);
    cyc(3);
    chk(full_n, 1'b0);
    @(posedge clk) retransmit_n <= 1'b0;
    @(posedge clk) retransmit_n <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      cyc(1);
      if (empty_n === 1'b0)
        seen = 1'b1;
    end
    chk({seen, empty_n}, 2'b11);
    rd1(18'h0_0000);
    $display("mark test done");
  endtask : t_mark
  // Main sequence and hang guard
  initial
  begin
    t_std();
    t_ft();
    t_mark();
    finish_test();
  end
  initial
  begin
    #2_000_000;
    fails++;
    finish_test();
  end
endmodule : tb
